//--- verilog/dac_ctrl_consts.svh
// register offsets, field positions, reset values and encodings of the converter control
//
// Function
// - code selects one of 4096 ladder taps
// - highest tap is code 4095
// - powered-down channel ladder disconnected from reference
// - two-bit select routes one of three sources
// - 00 supply, 01 bandgap, 10/11 pin
// - reset reloads default reference select bits
// - supply select keeps reference pin disconnected
// - power-down switches amplifier off, output hiz
// - 00 normal, 01 1k, 10 100k, 11 open
// - gain bit 0 unity, 1 double
// - supply reference forces unity gain
// - gain changes only on reset, write, call
// - converter code is unsigned binary
// - reset reloads code and updates output
// - code commits at final byte acknowledge
// - general call reset restores power-on code
`ifndef DAC_CTRL_CONSTS_SVH
`define DAC_CTRL_CONSTS_SVH

`define DAC_BITS 12
`define LADDER_ELEMS 4096
`define TAP_MAX 12'hfff
`define NUM_CH 2

// register indices; byte address is four times the index
`define IDX_CODE0 6'h00
`define IDX_CODE1 6'h01
`define IDX_VREF 6'h08
`define IDX_PD 6'h09
`define IDX_GAIN 6'h0a
`define IDX_COMMIT 6'h0c

`define GAIN_BIT0 8
`define POR_BIT 7
`define COMMIT_BIT 0
`define FIELD2_W 2

`define CODE_POR 12'h000
`define REF_POR 2'h0
`define PD_POR 2'h0
`define GAIN_POR 1'b0

`define REF_SUPPLY 2'h0
`define REF_BANDGAP 2'h1
`define REF_PIN_UNBUF 2'h2
`define REF_PIN_BUF 2'h3

`define PD_NORMAL 2'h0
`define PD_1K 2'h1
`define PD_100K 2'h2
`define PD_OPEN 2'h3

`endif

//--- verilog/dac_ctrl_pkg.sv
// types shared by the converter control modules
`include "dac_ctrl_consts.svh"

package dac_ctrl_pkg;

    typedef logic [`DAC_BITS-1:0] code_t;

    typedef struct packed {
        code_t code;
        logic [1:0] ref_sel;
        logic [1:0] pd_sel;
        logic gain;
    } chan_cfg_s;

    typedef struct packed {
        code_t tap;
        logic [1:0] ref_src;
        logic ladder_connect;
        logic ref_buf_en;
        logic pin_connect;
        logic amp_en;
        logic out_hiz;
        logic pull_1k_en;
        logic pull_100k_en;
        logic gain_two;
    } chan_ctrl_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        chan_cfg_s [`NUM_CH-1:0] staged;
        chan_cfg_s [`NUM_CH-1:0] active;
        logic por_flag;
        apb_rsp_s rsp;
        chan_ctrl_s [`NUM_CH-1:0] out;
    } state_s;

endpackage

//--- verilog/chan_decode.sv
// per-channel decode of the active settings into ladder and amplifier controls
`timescale 1ns/1ns
`include "dac_ctrl_consts.svh"

module chan_decode (
    input wire dac_ctrl_pkg::chan_cfg_s cfg,
    output dac_ctrl_pkg::chan_ctrl_s ctrl
);
    logic running;

    assign running = (cfg.pd_sel == `PD_NORMAL);

    always_comb begin
        // unsigned code is the tap directly; 4095 is the top tap of 4096 elements
        ctrl.tap = cfg.code;
        ctrl.ref_src = cfg.ref_sel;
        ctrl.ladder_connect = running;
        // bandgap and buffered pin both run the reference buffer
        ctrl.ref_buf_en = (cfg.ref_sel == `REF_BANDGAP) || (cfg.ref_sel == `REF_PIN_BUF);
        ctrl.pin_connect = running && cfg.ref_sel[1];
        ctrl.amp_en = running;
        ctrl.out_hiz = !running;
        ctrl.pull_1k_en = (cfg.pd_sel == `PD_1K);
        ctrl.pull_100k_en = (cfg.pd_sel == `PD_100K);
        ctrl.gain_two = cfg.gain && (cfg.ref_sel != `REF_SUPPLY);
    end

endmodule // chan_decode

//--- verilog/dac_ctrl.sv
// converter control top: apb register slave, staged settings, commit events, channel decode
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "dac_ctrl_consts.svh"

module dac_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire dac_ctrl_pkg::apb_req_s apb_req,
    output dac_ctrl_pkg::apb_rsp_s apb_rsp,
    input wire logic bor_event,
    input wire logic commit_ack,
    input wire logic gc_reset,
    output dac_ctrl_pkg::chan_ctrl_s [`NUM_CH-1:0] chan_ctrl,
    output logic por_flag
);
    dac_ctrl_pkg::state_s st_q;
    dac_ctrl_pkg::state_s st_d;
    dac_ctrl_pkg::chan_cfg_s cfg_por;
    dac_ctrl_pkg::chan_ctrl_s [`NUM_CH-1:0] dec;
    logic [5:0] idx;
    logic setup;
    logic access;
    logic hit;
    logic commit_now;
    logic [31:0] rdata;

    assign cfg_por = '{code: `CODE_POR, ref_sel: `REF_POR, pd_sel: `PD_POR, gain: `GAIN_POR};
    assign idx = apb_req.paddr[7:2];
    assign setup = apb_req.psel && !apb_req.penable;
    // the answer is prepared in setup, so every access phase completes in one cycle
    assign access = apb_req.psel && apb_req.penable && st_q.rsp.pready;

    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g++) begin : g_ch
            chan_decode u_dec (
                .cfg(st_q.active[g]),
                .ctrl(dec[g])
            );
        end
    endgenerate

    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        unique case (idx)
            `IDX_CODE0: rdata[`DAC_BITS-1:0] = st_q.active[0].code;
            `IDX_CODE1: rdata[`DAC_BITS-1:0] = st_q.active[1].code;
            `IDX_VREF: rdata[3:0] = {st_q.active[1].ref_sel, st_q.active[0].ref_sel};
            `IDX_PD: rdata[3:0] = {st_q.active[1].pd_sel, st_q.active[0].pd_sel};
            `IDX_GAIN: begin
                rdata[`GAIN_BIT0] = st_q.active[0].gain;
                rdata[`GAIN_BIT0+1] = st_q.active[1].gain;
                rdata[`POR_BIT] = st_q.por_flag;
            end
            `IDX_COMMIT: rdata = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        st_d = st_q;
        commit_now = 1'b0;

        // answer path
        st_d.rsp.pready = setup;
        st_d.rsp.pslverr = setup && !hit;
        if (setup) begin
            st_d.rsp.prdata = hit ? rdata : 32'h0000_0000;
        end

        // software fills the staging copy only; the channels see nothing yet
        if (access && apb_req.pwrite && hit) begin
            unique case (idx)
                `IDX_CODE0: st_d.staged[0].code = apb_req.pwdata[`DAC_BITS-1:0];
                `IDX_CODE1: st_d.staged[1].code = apb_req.pwdata[`DAC_BITS-1:0];
                `IDX_VREF: begin
                    st_d.staged[0].ref_sel = apb_req.pwdata[1:0];
                    st_d.staged[1].ref_sel = apb_req.pwdata[3:2];
                end
                `IDX_PD: begin
                    st_d.staged[0].pd_sel = apb_req.pwdata[1:0];
                    st_d.staged[1].pd_sel = apb_req.pwdata[3:2];
                end
                `IDX_GAIN: begin
                    st_d.staged[0].gain = apb_req.pwdata[`GAIN_BIT0];
                    st_d.staged[1].gain = apb_req.pwdata[`GAIN_BIT0+1];
                end
                `IDX_COMMIT: commit_now = apb_req.pwdata[`COMMIT_BIT];
                default: commit_now = 1'b0;
            endcase
        end

        // reading the gain/status word clears the reset flag
        if (access && !apb_req.pwrite && (idx == `IDX_GAIN)) begin
            st_d.por_flag = 1'b0;
        end

        // code, reference, gain and power-down move as one set
        if (commit_ack || commit_now) begin
            st_d.active = st_d.staged;
        end

        if (gc_reset) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                st_d.active[i] = cfg_por;
                st_d.staged[i] = cfg_por;
            end
        end

        // brown-out acts like a power-on; its set beats a same-cycle read clear
        if (bor_event) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                st_d.active[i] = cfg_por;
                st_d.staged[i] = cfg_por;
            end
            st_d.por_flag = 1'b1;
        end

        // decode lags the active settings by one cycle so outputs stay registered
        st_d.out = dec;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                st_q.staged[i] <= '{code: `CODE_POR, ref_sel: `REF_POR, pd_sel: `PD_POR,
                                    gain: `GAIN_POR};
                st_q.active[i] <= '{code: `CODE_POR, ref_sel: `REF_POR, pd_sel: `PD_POR,
                                    gain: `GAIN_POR};
                // outputs start powered in normal mode with supply reference, tap zero
                st_q.out[i] <= '{tap: `CODE_POR, ref_src: `REF_POR, ladder_connect: 1'b1,
                                 ref_buf_en: 1'b0, pin_connect: 1'b0, amp_en: 1'b1,
                                 out_hiz: 1'b0, pull_1k_en: 1'b0, pull_100k_en: 1'b0,
                                 gain_two: 1'b0};
            end
            st_q.por_flag <= 1'b1;
            st_q.rsp <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp = st_q.rsp;
    assign chan_ctrl = st_q.out;
    assign por_flag = st_q.por_flag;

endmodule // dac_ctrl

//--- test/serial_host.sv
// serial engine stand-in that raises commit and general call pulses
`timescale 1ns/1ns
module serial_host (
    input wire logic clk,
    output logic commit_ack,
    output logic gc_reset
);
    initial begin
        commit_ack = 1'b0;
        gc_reset = 1'b0;
    end
    // one-cycle pulse, launched and dropped just after rising edges
    task automatic pulse(input bit gc);
        @(posedge clk);
        if (gc) gc_reset <= 1'b1;
        else commit_ack <= 1'b1;
        @(posedge clk);
        commit_ack <= 1'b0;
        gc_reset <= 1'b0;
    endtask
endmodule // serial_host

//--- test/dac_ctrl_monitor.sv
// assertion checker on the converter control top ports
`timescale 1ns/1ns
`include "dac_ctrl_consts.svh"
module dac_ctrl_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire dac_ctrl_pkg::apb_req_s apb_req,
    input wire dac_ctrl_pkg::apb_rsp_s apb_rsp,
    input wire logic bor_event,
    input wire logic commit_ack,
    input wire logic gc_reset,
    input wire dac_ctrl_pkg::chan_ctrl_s [`NUM_CH-1:0] chan_ctrl,
    input wire logic por_flag
);
    logic ev;
    // superset of commit causes; extra cases only relax the check
    assign ev = commit_ack || gc_reset || bor_event || (apb_req.psel && apb_req.penable
        && apb_rsp.pready && apb_req.pwrite && apb_req.paddr[7:2] == `IDX_COMMIT);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_pd_amp_off: assert property (!chan_ctrl[0].ladder_connect |->
        chan_ctrl[0].out_hiz && !chan_ctrl[0].amp_en) else $error("amp on while down");
    a_supply_no_pin: assert property (chan_ctrl[0].ref_src == `REF_SUPPLY |->
        !chan_ctrl[0].pin_connect) else $error("pin on supply select");
    a_supply_unity: assert property (chan_ctrl[0].ref_src == `REF_SUPPLY |->
        !chan_ctrl[0].gain_two) else $error("gain two on supply");
    a_buf_code: assert property (chan_ctrl[0].ref_buf_en == chan_ctrl[0].ref_src[0])
        else $error("buffer enable mismatch");
    a_pull_single: assert property ($onehot0({chan_ctrl[0].pull_1k_en,
        chan_ctrl[0].pull_100k_en, chan_ctrl[0].amp_en})) else $error("pull overlap");
    a_gc_default: assert property (gc_reset |-> ##2 chan_ctrl[0].tap == `CODE_POR)
        else $error("code not restored");
    a_bor_reload: assert property (bor_event |=> por_flag ##1
        chan_ctrl[0].tap == `CODE_POR) else $error("brown-out reload missing");
    a_hold_quiet: assert property (!$past(ev, 2) |-> $stable(chan_ctrl))
        else $error("output moved without event");
    cover property (commit_ack ##2 chan_ctrl[0].gain_two);
    cover property (gc_reset ##2 chan_ctrl[0].ladder_connect);
    cover property (bor_event ##1 por_flag);
endmodule // dac_ctrl_monitor
bind dac_ctrl dac_ctrl_monitor dac_ctrl_monitor_inst (.clk(clk), .rst_b(rst_b),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .bor_event(bor_event), .commit_ack(commit_ack),
    .gc_reset(gc_reset), .chan_ctrl(chan_ctrl), .por_flag(por_flag));

//--- test/tb_top.sv
// self-checking bench for the converter control top
`timescale 1ns/1ns
`include "dac_ctrl_consts.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic bor_event = 1'b0;
    logic commit_ack, gc_reset, por_flag, e;
    logic [31:0] d;
    int miscompares = 0;
    int checks_done = 0;
    dac_ctrl_pkg::apb_req_s req = '0;
    dac_ctrl_pkg::apb_rsp_s rsp;
    dac_ctrl_pkg::chan_ctrl_s [`NUM_CH-1:0] cc;
    always #5 clk = ~clk;
    dac_ctrl dac_ctrl_inst (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
        .bor_event(bor_event), .commit_ack(commit_ack), .gc_reset(gc_reset),
        .chan_ctrl(cc), .por_flag(por_flag));
    serial_host serial_host_inst (.clk(clk), .commit_ack(commit_ack), .gc_reset(gc_reset));
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        d = rsp.prdata;
        e = rsp.pslverr;
        if (n >= 20) miscompares++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] x);
        apb(1'b0, idx, '0);
        chk("read", x, d);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(`IDX_GAIN, 32'h0000_0080);
        rd(`IDX_GAIN, 32'h0000_0000);
        chk("tap", {12'h000, 1'b1}, {cc[0].tap, cc[0].ladder_connect});
        apb(1'b1, `IDX_CODE0, 32'h0000_0fff);
        apb(1'b1, `IDX_CODE1, 32'h0000_05a5);
        rd(`IDX_CODE0, 32'h0000_0000);
        serial_host_inst.pulse(1'b0);
        settle();
        chk("tap", 12'hfff, cc[0].tap);
        chk("tap1", 12'h5a5, cc[1].tap);
        for (logic [2:0] r = 0; r < 4; r++) begin
            apb(1'b1, `IDX_VREF, {28'h0, r[1:0], r[1:0]});
            apb(1'b1, `IDX_GAIN, 32'h0000_0300);
            serial_host_inst.pulse(1'b0);
            settle();
            chk("ref", {r[1:0], r[0], r[1], r[1:0] != 2'h0}, {cc[0].ref_src,
                cc[0].ref_buf_en, cc[0].pin_connect, cc[0].gain_two});
        end
        apb(1'b1, `IDX_GAIN, 32'h0000_0000);
        apb(1'b1, `IDX_COMMIT, 32'h0000_0001);
        settle();
        chk("gain", 1'b0, cc[0].gain_two);
        for (logic [2:0] p = 0; p < 4; p++) begin
            apb(1'b1, `IDX_PD, {28'h0, p[1:0], p[1:0]});
            serial_host_inst.pulse(1'b0);
            settle();
            chk("pd", {p == 0, p == 0, p != 0, p == 1, p == 2, p == 0},
                {cc[1].ladder_connect, cc[1].amp_en, cc[1].out_hiz, cc[1].pull_1k_en,
                cc[1].pull_100k_en, cc[1].pin_connect});
        end
        rd(`IDX_CODE1, 32'h0000_05a5);
        rd(`IDX_VREF, 32'h0000_000f);
        rd(`IDX_PD, 32'h0000_000f);
        apb(1'b0, 6'h3f, '0);
        // error flag and data checked apart so neither is cut off by the 32-bit compare
        chk("unmapped_err", 32'h0000_0001, {31'h0, e});
        chk("unmapped_data", 32'h0000_0000, d);
        serial_host_inst.pulse(1'b1);
        settle();
        chk("gc", {12'h000, 2'h0, 1'b1}, {cc[0].tap, cc[0].ref_src, cc[0].amp_en});
        apb(1'b1, `IDX_CODE0, 32'h0000_0123);
        serial_host_inst.pulse(1'b0);
        settle();
        chk("tap", 12'h123, cc[0].tap);
        @(posedge clk);
        bor_event <= 1'b1;
        @(posedge clk);
        bor_event <= 1'b0;
        settle();
        chk("bor", 12'h000, cc[0].tap);
        chk("por", 1'b1, por_flag);
        rd(`IDX_GAIN, 32'h0000_0080);
        end_of_test();
    end
endmodule // tb_top
